// ---- hdl/rlmc_pkg.sv ----
package rlmc_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned APB_AW = 8;
	localparam logic [APB_AW-1:0] OFS_MODE = 8'h00;
	localparam logic [APB_AW-1:0] OFS_AUDIO = 8'h04;
	// receive_mode_state field positions
	localparam int unsigned BIT_RATE_PICK = 6;
	localparam int unsigned BIT_AUTO_AUD = 5;
	localparam int unsigned BIT_FAST = 4;
	localparam int unsigned BIT_COAX = 3;
	localparam int unsigned BIT_RPT = 2;
	localparam logic RST_RATE_PICK = 1'b0;
	localparam logic RST_AUTO_AUD = 1'b1;
	// Audio status register fields
	localparam int unsigned AUD_MODE_LSB = 0;
	localparam int unsigned AUD_MANUAL_LSB = 4;
	localparam int unsigned AUD_SETTLE_BIT = 8;
	// Return path rates in Mbps
	localparam int unsigned RATE_SLOW_MBPS = 5;
	localparam int unsigned RATE_MID_MBPS = 10;
	localparam int unsigned RATE_FAST_MBPS = 20;
	localparam int unsigned DIV_SLOW = CLK_MHZ / RATE_SLOW_MBPS;
	localparam int unsigned DIV_MID = CLK_MHZ / RATE_MID_MBPS;
	localparam int unsigned DIV_FAST = CLK_MHZ / RATE_FAST_MBPS;
	// Quiet time after a rate change, in ns
	localparam int unsigned SETTLE_NS = 2000;
	localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	// Strap code bits
	localparam int unsigned STRAP_FAST = 0;
	localparam int unsigned STRAP_COAX = 1;
	localparam int unsigned STRAP_RPT = 2;
	// Aux data codes that name an audio serial format
	localparam logic [7:0] AUX_STD = 8'h10;
	localparam logic [7:0] AUX_LEFT = 8'h11;
	localparam logic [7:0] AUX_RIGHT = 8'h12;
	localparam logic [7:0] AUX_TDM = 8'h13;

	typedef enum logic [1:0] {
		RLMC_RATE_SLOW = 2'b00,
		RLMC_RATE_MID  = 2'b01,
		RLMC_RATE_FAST = 2'b10
	} rlmc_rate_t;

	typedef enum logic [1:0] {
		RLMC_AUD_STD   = 2'b00,
		RLMC_AUD_LEFT  = 2'b01,
		RLMC_AUD_RIGHT = 2'b10,
		RLMC_AUD_TDM   = 2'b11
	} rlmc_aud_t;

	typedef enum logic {
		RLMC_BUS_IDLE = 1'b0,
		RLMC_BUS_RESP = 1'b1
	} rlmc_bus_t;

	typedef struct packed {
		rlmc_rate_t rate;
		logic       coax;
		logic       repeater;
		logic       autoAudio;
		rlmc_aud_t  audioMode;
	} rlmc_link_cfg_t;

	typedef struct packed {
		logic ratePick;
		logic autoAud;
		logic fast;
		logic coax;
		logic repeater;
	} rlmc_mode_reg_t;
endpackage

// ---- hdl/rlmc_top.sv ----
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Notes on behaviour
// R1 - Fast bit clear: return path runs 5 Mbps if bit 6 is 0, else 10
// R2 - Fast bit (bit 4) set: bit 6 ignored, return path runs 20 Mbps
// R3 - Controller puts serializer in auto-acknowledge before changing rate bits; no such control here, rateSettling only flags the quiet time
// R4 - Auto audio bit (bit 5, reset 1) set: audio mode from aux codes
// R5 - Cable bit (bit 3): 0 shielded twisted pair, 1 coax
// R6 - Fast, cable and repeater bits preset from the mode strap pin
// R7 - Repeater bit (bit 2) read-only, reports strap; writes ignored
module rlmc_top #(
	parameter int unsigned SETTLE_CYCLES = rlmc_pkg::SETTLE_CYC
) (
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [rlmc_pkg::APB_AW-1:0]  paddr,
	input  wire logic [31:0]                  pwdata,
	input  wire logic [3:0]                   pstrb,
	output logic                              pready,
	output logic [31:0]                       prdata,
	output logic                              pslverr,
	input  wire logic [2:0]                   strapPinConfig,
	input  wire logic                         auxValid,
	input  wire logic [7:0]                   auxCode,
	output rlmc_pkg::rlmc_link_cfg_t          linkCfg,
	output logic                              returnPathTick,
	output logic                              rateSettling
);
	import rlmc_pkg::*;

	localparam int unsigned SCW = $clog2(SETTLE_CYCLES + 1);
	localparam int unsigned DVW = $clog2(DIV_SLOW + 1);

	if (SETTLE_CYCLES < 1) begin : gBadSettle
		$error("SETTLE_CYCLES must be at least one");
	end
	if (DIV_FAST < 2) begin : gBadClock
		$error("Clock too slow for the fastest return path rate");
	end

	function automatic rlmc_rate_t pickRate(input logic fast,
		input logic ratePick);
		if (fast)
			pickRate = RLMC_RATE_FAST; // R2
		else if (ratePick)
			pickRate = RLMC_RATE_MID; // R1
		else
			pickRate = RLMC_RATE_SLOW; // R1
	endfunction

	function automatic logic [DVW-1:0] rateDiv(input rlmc_rate_t r);
		case (r)
			RLMC_RATE_FAST: rateDiv = DVW'(DIV_FAST);
			RLMC_RATE_MID:  rateDiv = DVW'(DIV_MID);
			default:        rateDiv = DVW'(DIV_SLOW);
		endcase
	endfunction

	function automatic logic [2:0] decodeAux(input logic [7:0] code);
		// Bit 2 marks a recognised code, bits 1:0 the format
		case (code)
			AUX_STD:   decodeAux = {1'b1, RLMC_AUD_STD};
			AUX_LEFT:  decodeAux = {1'b1, RLMC_AUD_LEFT};
			AUX_RIGHT: decodeAux = {1'b1, RLMC_AUD_RIGHT};
			AUX_TDM:   decodeAux = {1'b1, RLMC_AUD_TDM};
			default:   decodeAux = 3'h0;
		endcase
	endfunction

	// Strap synchroniser, left without reset so it is settled at release
	logic [2:0] strapMeta_q;
	logic [2:0] strapSync_q;

	always_ff @(posedge clk) begin
		strapMeta_q <= strapPinConfig;
		strapSync_q <= strapMeta_q;
	end

	// Register state
	rlmc_mode_reg_t mode_q, mode_d;
	logic           strapDone_q, strapDone_d;
	rlmc_aud_t      manualAud_q, manualAud_d;
	rlmc_aud_t      detAud_q, detAud_d;

	// Bus state
	rlmc_bus_t   bus_q, bus_d;
	logic        pready_q, pready_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pslverr_q, pslverr_d;

	logic wrEn;
	logic wrMode;
	logic wrAud;
	logic hitMode;
	logic hitAud;
	logic [31:0] rdWord;

	always_comb begin
		hitMode = (paddr == OFS_MODE);
		hitAud = (paddr == OFS_AUDIO);
		// Write lands on the completing edge, while pready is high
		wrEn = psel && penable && pwrite && (bus_q == RLMC_BUS_RESP);
		wrMode = wrEn && hitMode && pstrb[0];
		wrAud = wrEn && hitAud && pstrb[0];
		rdWord = 32'h0;
		if (hitMode) begin
			rdWord[BIT_RATE_PICK] = mode_q.ratePick;
			rdWord[BIT_AUTO_AUD] = mode_q.autoAud;
			rdWord[BIT_FAST] = mode_q.fast;
			rdWord[BIT_COAX] = mode_q.coax;
			rdWord[BIT_RPT] = mode_q.repeater;
		end else if (hitAud) begin
			rdWord[AUD_MODE_LSB +: 2] = linkCfg.audioMode;
			rdWord[AUD_MANUAL_LSB +: 2] = manualAud_q;
			rdWord[AUD_SETTLE_BIT] = rateSettling;
		end
	end

	// APB slave: one wait state, answer registered
	always_comb begin
		bus_d = bus_q;
		pready_d = 1'b0;
		prdata_d = prdata_q;
		pslverr_d = 1'b0;
		case (bus_q)
			RLMC_BUS_IDLE: begin
				if (psel && penable) begin
					bus_d = RLMC_BUS_RESP;
					pready_d = 1'b1;
					pslverr_d = !(hitMode || hitAud);
					prdata_d = pwrite ? 32'h0 : rdWord;
				end
			end
			RLMC_BUS_RESP: begin
				bus_d = RLMC_BUS_IDLE;
			end
			default: begin
				bus_d = RLMC_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_q <= RLMC_BUS_IDLE;
			pready_q <= 1'b0;
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end else begin
			bus_q <= bus_d;
			pready_q <= pready_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	// Mode register, preset from the strap once after reset release
	always_comb begin
		mode_d = mode_q;
		strapDone_d = 1'b1;
		manualAud_d = manualAud_q;
		if (!strapDone_q) begin
			mode_d.fast = strapSync_q[STRAP_FAST]; // R6
			mode_d.coax = strapSync_q[STRAP_COAX]; // R6
			mode_d.repeater = strapSync_q[STRAP_RPT]; // R6
		end else if (wrMode) begin
			mode_d.ratePick = pwdata[BIT_RATE_PICK];
			mode_d.autoAud = pwdata[BIT_AUTO_AUD];
			mode_d.fast = pwdata[BIT_FAST];
			mode_d.coax = pwdata[BIT_COAX]; // R5
			mode_d.repeater = mode_q.repeater; // R7
		end
		if (wrAud)
			manualAud_d = rlmc_aud_t'(pwdata[AUD_MANUAL_LSB +: 2]);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_q.ratePick <= RST_RATE_PICK;
			mode_q.autoAud <= RST_AUTO_AUD; // R4
			mode_q.fast <= 1'b0;
			mode_q.coax <= 1'b0;
			mode_q.repeater <= 1'b0;
			strapDone_q <= 1'b0;
			manualAud_q <= RLMC_AUD_STD;
		end else begin
			mode_q <= mode_d;
			strapDone_q <= strapDone_d;
			manualAud_q <= manualAud_d;
		end
	end

	// Audio format tracking from aux codes
	logic [2:0] auxDec;

	always_comb begin
		auxDec = decodeAux(auxCode);
		detAud_d = detAud_q;
		if (auxValid && auxDec[2])
			detAud_d = rlmc_aud_t'(auxDec[1:0]); // R4
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			detAud_q <= RLMC_AUD_STD;
		else
			detAud_q <= detAud_d;
	end

	// Link configuration and return path bit clock enable
	rlmc_link_cfg_t cfg_q, cfg_d;
	logic [DVW-1:0] div_q, div_d;
	logic           tick_q, tick_d;
	logic [SCW-1:0] settle_q, settle_d;
	logic           settling_q, settling_d;

	always_comb begin
		cfg_d.rate = pickRate(mode_q.fast, mode_q.ratePick); // R1 R2
		cfg_d.coax = mode_q.coax; // R5
		cfg_d.repeater = mode_q.repeater; // R7
		cfg_d.autoAudio = mode_q.autoAud;
		cfg_d.audioMode = mode_q.autoAud ? detAud_d : manualAud_q; // R4
		tick_d = 1'b0;
		div_d = div_q + DVW'(1);
		// Rate change restarts the bit divider and flags settling
		if (cfg_d.rate != cfg_q.rate) begin
			div_d = '0;
			settle_d = SCW'(SETTLE_CYCLES);
		end else begin
			if (div_q >= rateDiv(cfg_q.rate) - DVW'(1)) begin
				div_d = '0;
				tick_d = 1'b1;
			end
			settle_d = (settle_q != '0) ? settle_q - SCW'(1) : settle_q;
		end
		// Errors on the return path are expected while this is high R3
		settling_d = (settle_d != '0);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_q <= '{RLMC_RATE_SLOW, 1'b0, 1'b0, RST_AUTO_AUD,
				RLMC_AUD_STD};
			div_q <= '0;
			tick_q <= 1'b0;
			settle_q <= '0;
			settling_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			div_q <= div_d;
			tick_q <= tick_d;
			settle_q <= settle_d;
			settling_q <= settling_d;
		end
	end

	assign pready = pready_q;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;
	assign linkCfg = cfg_q;
	assign returnPathTick = tick_q;
	assign rateSettling = settling_q;
endmodule

// ---- tb/rlmc_monitor.sv ----
`timescale 1ns/1ns
module rlmc_monitor (
	input wire logic                    clk,
	input wire logic                    sys_rst,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [7:0]              paddr,
	input wire logic [31:0]             pwdata,
	input wire logic [3:0]              pstrb,
	input wire logic                    pready,
	input wire logic [2:0]              strapPinConfig,
	input wire logic                    auxValid,
	input wire logic [7:0]              auxCode,
	input wire rlmc_pkg::rlmc_link_cfg_t linkCfg,
	input wire logic                    returnPathTick
);
	import rlmc_pkg::*;
	logic wr;
	// Completing edge only: pready high
	assign wr = psel && penable && pwrite && pready && pstrb[0]
		&& paddr == OFS_MODE;
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	rate_pick_a: assert property (wr && !pwdata[4] |-> ##2
		linkCfg.rate == ($past(pwdata[6], 2) ? RLMC_RATE_MID
			: RLMC_RATE_SLOW))
		else $error("rate differs from pick bit");
	fast_rate_a: assert property (wr && pwdata[4] |-> ##2
		linkCfg.rate == RLMC_RATE_FAST) else $error("fast rate not set");
	fast_tick_a: assert property (
		returnPathTick && linkCfg.rate == RLMC_RATE_FAST |=>
		!returnPathTick [*4] ##1
		(returnPathTick || linkCfg.rate != RLMC_RATE_FAST))
		else $error("fast tick spacing wrong");
	aux_mode_a: assert property (
		auxValid && auxCode[7:2] == 6'h04 && linkCfg.autoAudio |=>
		linkCfg.audioMode == $past(auxCode[1:0]))
		else $error("audio mode not taken from code");
	auto_reset_a: assert property ($fell(sys_rst) |-> linkCfg.autoAudio)
		else $error("auto audio reset value wrong");
	cable_write_a: assert property (wr |-> ##2
		linkCfg.coax == $past(pwdata[3], 2))
		else $error("cable bit not applied");
	strap_load_a: assert property ($fell(sys_rst) |-> ##2
		linkCfg.coax == strapPinConfig[STRAP_COAX] &&
		linkCfg.repeater == strapPinConfig[STRAP_RPT])
		else $error("strap not loaded");
	repeater_ro_a: assert property (wr |-> ##2 $stable(linkCfg.repeater))
		else $error("repeater bit written");
	cover property (wr && pwdata[4]);
	cover property (auxValid && linkCfg.autoAudio);
	cover property (returnPathTick && linkCfg.rate == RLMC_RATE_MID);
endmodule
bind rlmc_top rlmc_monitor rlmc_monitor_i (.clk, .sys_rst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pstrb, .pready, .strapPinConfig, .auxValid,
	.auxCode, .linkCfg, .returnPathTick);

// ---- tb/rlmc_ser_model.sv ----
`timescale 1ns/1ns
module rlmc_ser_model (
	input wire logic clk,
	output logic     auxValid,
	output logic [7:0] auxCode
);
	initial begin
		auxValid = 1'b0;
		auxCode = 8'h00;
	end
	// Code line scrambled after the strobe so stale data never matches
	task automatic send_aux(input logic [7:0] code);
		@(posedge clk);
		auxValid <= 1'b1;
		auxCode <= code;
		@(posedge clk);
		auxValid <= 1'b0;
		auxCode <= ~code;
	endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ns
module tb;
	import rlmc_pkg::*;
	logic           clk = 1'b0;
	logic           sys_rst = 1'b1;
	logic           psel = 1'b0;
	logic           penable = 1'b0;
	logic           pwrite = 1'b0;
	logic [7:0]     paddr = 8'h00;
	logic [31:0]    pwdata = 32'h0;
	logic [3:0]     pstrb = 4'hf;
	logic [2:0]     strapPinConfig = 3'h6;
	logic           pready, pslverr, returnPathTick, rateSettling, err;
	logic           auxValid;
	logic [7:0]     auxCode;
	logic [31:0]    prdata, rd, w;
	rlmc_link_cfg_t linkCfg;
	int             error_cnt = 0;
	int             total_checks = 0;
	int             cyc = 0;
	int             n;
	always #5 clk = ~clk;
	rlmc_top #(.SETTLE_CYCLES(4)) rlmc_top_i (.clk, .sys_rst, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
		.pslverr, .strapPinConfig, .auxValid, .auxCode, .linkCfg,
		.returnPathTick, .rateSettling);
	rlmc_ser_model rlmc_ser_model_i (.clk, .auxValid, .auxCode);
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wt, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wt;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic do_reset(input logic [2:0] s);
		strapPinConfig <= s;
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic tick_gap(input int exp);
		n = 0;
		while (returnPathTick !== 1'b1 && n < 99) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (returnPathTick !== 1'b1 && n < 99);
		check(n, exp);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Cuts the whole run short after 20000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end
	initial begin
		do_reset(3'h6);
		apb(1'b0, OFS_MODE, 32'h0);
		check(rd, 32'h2c);
		check({25'h0, linkCfg}, 32'h1c);
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			w = {25'h0, i[0], 1'b1, i[1], ~i[0], 3'h0};
			apb(1'b1, OFS_MODE, w);
			// Rate changes for i of 1 and 2 only
			apb(1'b0, OFS_AUDIO, 32'h0);
			check({31'h0, rd[AUD_SETTLE_BIT]}, i == 1 || i == 2);
			check({31'h0, rateSettling}, i == 1 || i == 2);
			apb(1'b0, OFS_MODE, 32'h0);
			check(rd, w | 32'h4);
			check({30'h0, linkCfg.rate}, i[1] ? 2 : i[0]);
			check({31'h0, linkCfg.coax}, {31'h0, ~i[0]});
			tick_gap(i[1] ? DIV_FAST : i[0] ? DIV_MID : DIV_SLOW);
			// Next rate change only once the quiet time is over
			apb(1'b0, OFS_AUDIO, 32'h0);
			check({31'h0, rd[AUD_SETTLE_BIT]}, 0);
		end
		$display("rate test done");
		pstrb <= 4'h0;
		apb(1'b1, OFS_MODE, 32'h0);
		pstrb <= 4'hf;
		apb(1'b0, OFS_MODE, 32'h0);
		check(rd, 32'h74);
		apb(1'b0, 8'h08, 32'h0);
		check({31'h0, err}, 1);
		check(rd, 0);
		$display("refusal test done");
		for (int k = 0; k < 5; k++) begin
			rlmc_ser_model_i.send_aux(AUX_STD + 8'(k));
			apb(1'b0, OFS_AUDIO, 32'h0);
			check({30'h0, rd[1:0]}, k < 4 ? k : 3);
			check({30'h0, linkCfg.audioMode}, k < 4 ? k : 3);
		end
		apb(1'b1, OFS_MODE, 32'h0);
		rlmc_ser_model_i.send_aux(AUX_LEFT);
		@(posedge clk);
		check({31'h0, linkCfg.autoAudio}, 0);
		check({31'h0, linkCfg.audioMode === RLMC_AUD_LEFT}, 0);
		apb(1'b1, OFS_AUDIO, 32'h20);
		apb(1'b0, OFS_AUDIO, 32'h0);
		check(rd & 32'h33, 32'h22);
		$display("audio test done");
		do_reset(3'h1);
		apb(1'b0, OFS_MODE, 32'h0);
		check(rd, 32'h30);
		check({30'h0, linkCfg.rate}, 2);
		$display("strap test done");
		end_of_test();
	end
endmodule
